// ---- core/cvs_cfg.svh ----
// Constants of the cell voltage channel select block: offsets, resets, widths.
// Included by the package and by every design file that needs a figure.
`ifndef CVS_CFG_SVH
`define CVS_CFG_SVH

// ------------------------------------------------------------------
// Register map
// ------------------------------------------------------------------
`define CVS_ADDR_W         8
`define CVS_DATA_W         16
`define CVS_ADDR_LOW       8'h05
`define CVS_ADDR_HIGH      8'h06

// ------------------------------------------------------------------
// Field layout
// ------------------------------------------------------------------
`define CVS_NCELLS         17
`define CVS_LOW_W          16
`define CVS_HIGH_W         6
`define CVS_CELL17_BIT     0
`define CVS_HIGH_RSV_MSB   5
`define CVS_HIGH_RSV_LSB   1
`define CVS_HIGH_RO_MSB    15
`define CVS_HIGH_RO_LSB    6

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define CVS_LOW_RST        16'hffff
`define CVS_HIGH_RST       6'h01
`define CVS_CELLS_RST      17'h1ffff
`define CVS_DATA_ZERO      16'h0000
`define CVS_RO_ZERO        10'h000

`endif

// ---- core/cvs_pkg.sv ----
// Types shared by the cell voltage channel select design files.
// Assumes cvs_cfg.svh is on the include path.
`include "cvs_cfg.svh"

package cvs_pkg;

    typedef logic [`CVS_ADDR_W-1:0] cvs_addr_t;
    typedef logic [`CVS_DATA_W-1:0] cvs_data_t;
    typedef logic [`CVS_NCELLS-1:0] cvs_cells_t;

    typedef enum logic [1:0]
    {
        CVS_SEL_NONE = 2'b00,
        CVS_SEL_LOW  = 2'b01,
        CVS_SEL_HIGH = 2'b10
    } cvs_sel_t;

endpackage

// ---- core/cvs_reg_if.sv ----
// Write port and stored value of one configuration register.
// Assumes both ends run on the same clock as the register file.
`timescale 1ns/1ps

interface cvs_reg_if #(parameter int W = 16);

    logic         ce;
    logic         we;
    logic [W-1:0] wdata;
    logic [W-1:0] q;

    modport ctrl  (output ce, output we, output wdata, input q);
    modport store (input ce, input we, input wdata, output q);

endinterface

// ---- core/cvs_field_reg.sv ----
// One writable register with a constant reset value.
// Assumes the controlling side gives it a clock enable and a write strobe.
`timescale 1ns/1ps

module cvs_field_reg
    import cvs_pkg::*;
#(
    parameter int           W   = 16,
    parameter logic [W-1:0] RST = '0
)
(
    input  wire logic clock,
    input  wire logic nrst,
    cvs_reg_if.store  port
);

    logic [W-1:0] value_ff;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            value_ff <= RST;
        end
        else if (port.ce && port.we)
        begin
            value_ff <= port.wdata;
        end
    end

    assign port.q = value_ff;

endmodule

// ---- core/cvs_cell_select.sv ----
// Cell voltage channel select register bank and its enable vector.
// Assumes the serial register interface decoder sits on the same clock and
// hands over single-cycle read and write strobes with address and data.
//
// Notes on behaviour
// - Register 0x05 holds enables for cells 1-16, cell n at bit n-1.
// - An enable of 1 measures the cell, 0 leaves it out.
// - After reset all seventeen cell enables read one.
// - Cell 17 enable lives at bit 0 of register 0x06, read/write.
`timescale 1ns/1ps
`include "cvs_cfg.svh"

module cvs_cell_select
    import cvs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire cvs_addr_t  reg_addr,
    input  wire cvs_data_t  reg_wdata,
    output cvs_data_t       reg_rdata_ff,
    output logic            reg_rvalid_ff,
    output cvs_cells_t      cell_measure_on
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    cvs_sel_t sel;

    always_comb
    begin
        if (reg_addr == `CVS_ADDR_LOW)
        begin
            sel = CVS_SEL_LOW;
        end
        else if (reg_addr == `CVS_ADDR_HIGH)
        begin
            sel = CVS_SEL_HIGH;
        end
        else
        begin
            sel = CVS_SEL_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    cvs_reg_if #(.W(`CVS_LOW_W))  low_if  ();
    cvs_reg_if #(.W(`CVS_HIGH_W)) high_if ();

    assign low_if.ce     = clk_en;
    assign low_if.we     = reg_wr && (sel == CVS_SEL_LOW);
    assign low_if.wdata  = reg_wdata[`CVS_LOW_W-1:0];
    assign high_if.ce    = clk_en;
    assign high_if.we    = reg_wr && (sel == CVS_SEL_HIGH);
    // Bits above the stored field are dropped; they read back as zero.
    assign high_if.wdata = reg_wdata[`CVS_HIGH_W-1:0];

    cvs_field_reg #(
        .W   (`CVS_LOW_W),
        .RST (`CVS_LOW_RST)
    ) u_low (
        .clock (clock),
        .nrst  (nrst),
        .port  (low_if)
    );

    cvs_field_reg #(
        .W   (`CVS_HIGH_W),
        .RST (`CVS_HIGH_RST)
    ) u_high (
        .clock (clock),
        .nrst  (nrst),
        .port  (high_if)
    );

    // ------------------------------------------------------------------
    // Enable vector to the measurement sequencer
    // ------------------------------------------------------------------
    // Each bit is a stored flop bit; no logic sits between them and the port.
    genvar gi;
    generate
        for (gi = 0; gi < `CVS_LOW_W; gi++)
        begin : g_cell
            assign cell_measure_on[gi] = low_if.q[gi];
        end
    endgenerate
    assign cell_measure_on[`CVS_NCELLS-1] =
        high_if.q[`CVS_CELL17_BIT];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    cvs_data_t nxt_rdata;

    always_comb
    begin
        nxt_rdata = `CVS_DATA_ZERO;
        if (sel == CVS_SEL_LOW)
        begin
            nxt_rdata = low_if.q;
        end
        else if (sel == CVS_SEL_HIGH)
        begin
            nxt_rdata = {`CVS_RO_ZERO, high_if.q};
        end
    end

    // Read data is held until the next read so a slow shifter may sample it.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata_ff <= `CVS_DATA_ZERO;
        end
        else if (clk_en && reg_rd)
        begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rvalid_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_rvalid_ff <= reg_rd;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    logic wr_low;
    logic wr_high;
    logic rd_high;

    assign wr_low  = clk_en && reg_wr && (reg_addr == `CVS_ADDR_LOW);
    assign wr_high = clk_en && reg_wr && (reg_addr == `CVS_ADDR_HIGH);
    assign rd_high = clk_en && reg_rd && (reg_addr == `CVS_ADDR_HIGH);

    property p_low_write;
        wr_low |=> cell_measure_on[`CVS_LOW_W-1:0] ==
                   $past(reg_wdata[`CVS_LOW_W-1:0]);
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("cell 1-16 enables differ from written value");

    property p_high_write;
        wr_high |=> cell_measure_on[`CVS_NCELLS-1] == $past(reg_wdata[0]);
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("cell 17 enable differs from written bit 0");

    property p_hold;
        !(wr_low || wr_high) |=> $stable(cell_measure_on);
    endproperty
    a_hold: assert property (p_hold)
        else $error("cell enables changed without a write");

    property p_low_read;
        clk_en && reg_rd && (reg_addr == `CVS_ADDR_LOW) && !reg_wr
            |=> reg_rvalid_ff &&
                reg_rdata_ff == $past(cell_measure_on[`CVS_LOW_W-1:0]);
    endproperty
    a_low_read: assert property (p_low_read)
        else $error("read of low cell register returned wrong data");

    property p_high_ro_zero;
        rd_high |=> reg_rdata_ff[`CVS_HIGH_RO_MSB:`CVS_HIGH_RO_LSB] ==
                    `CVS_RO_ZERO;
    endproperty
    a_high_ro_zero: assert property (p_high_ro_zero)
        else $error("read-only bits of high cell register not zero");

    property p_rsv_readback;
        wr_high ##1 (rd_high && !reg_wr)
            |=> reg_rdata_ff[`CVS_HIGH_RSV_MSB:`CVS_HIGH_RSV_LSB] ==
                $past(reg_wdata[`CVS_HIGH_RSV_MSB:`CVS_HIGH_RSV_LSB], 2);
    endproperty
    a_rsv_readback: assert property (p_rsv_readback)
        else $error("reserved bits did not read back as written");

    property p_reset_on;
        $rose(nrst) |-> cell_measure_on == `CVS_CELLS_RST;
    endproperty
    a_reset_on: assert property (p_reset_on)
        else $error("cell enables not all on after reset");

    property p_freeze;
        !clk_en |=> $stable(cell_measure_on) && $stable(reg_rdata_ff) &&
                    $stable(reg_rvalid_ff);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_unmapped;
        clk_en && reg_rd && reg_addr != `CVS_ADDR_LOW &&
            reg_addr != `CVS_ADDR_HIGH |=> reg_rdata_ff == `CVS_DATA_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero data");

    property p_rvalid_pulse;
        clk_en && !reg_rd |=> !reg_rvalid_ff;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse)
        else $error("read valid without a read");

    property p_cov_cell17_off;
        wr_high && !reg_wdata[0];
    endproperty
    c_cov_cell17_off: cover property (p_cov_cell17_off);

    property p_cov_low_partial;
        wr_low ##1 rd_high;
    endproperty
    c_cov_low_partial: cover property (p_cov_low_partial);

    property p_cov_read_b2b;
        (clk_en && reg_rd) [*2];
    endproperty
    c_cov_read_b2b: cover property (p_cov_read_b2b);

    property p_cov_freeze_write;
        !clk_en && reg_wr;
    endproperty
    c_cov_freeze_write: cover property (p_cov_freeze_write);

endmodule

// ---- testbench/cvs_host_model.sv ----
// Host side of the register port: single writes, reads, read-modify-write.
// Assumes the bench owns clock and reset; all changes land at falling edges.
`timescale 1ns/1ps

module cvs_host_model
    import cvs_pkg::*;
(
    input  wire logic      clock,
    output logic           reg_wr,
    output logic           reg_rd,
    output cvs_addr_t      reg_addr,
    output cvs_data_t      reg_wdata,
    input  wire cvs_data_t reg_rdata_ff,
    input  wire logic      reg_rvalid_ff
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
    end

    task automatic write(input cvs_addr_t a, input cvs_data_t d);
        @(negedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge clock);
        reg_wr <= 1'b0;
        // Released data shows the inverse so stale values cannot pass.
        reg_wdata <= ~d;
    endtask

    task automatic read(input cvs_addr_t a, output cvs_data_t d,
                        output logic v);
        @(negedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(negedge clock);
        reg_rd <= 1'b0;
        d = reg_rdata_ff;
        v = reg_rvalid_ff;
    endtask

    // A write followed at once by a read, with no idle cycle between.
    task automatic write_read(input cvs_addr_t wa, input cvs_data_t wd,
                              input cvs_addr_t ra, output cvs_data_t d,
                              output logic v);
        @(negedge clock);
        reg_wr <= 1'b1;
        reg_addr <= wa;
        reg_wdata <= wd;
        @(negedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= ra;
        reg_wdata <= ~wd;
        @(negedge clock);
        reg_rd <= 1'b0;
        d = reg_rdata_ff;
        v = reg_rvalid_ff;
    endtask

    // Changing one cell keeps the other enables; changing cell 17 also zeroes reserved bits.
    task automatic set_cell(input int n, input logic on);
        cvs_data_t d;
        logic      v;
        if (n == 17)
        begin
            read(8'h06, d, v);
            d = {15'h0000, on};
            write(8'h06, d);
        end
        else
        begin
            read(8'h05, d, v);
            d[n-1] = on;
            write(8'h05, d);
        end
    endtask
endmodule

// ---- testbench/cvs_cell_select_bench.sv ----
// Self-checking bench of the cell select register bank.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/1ps

module cvs_cell_select_bench
    import cvs_pkg::*;
();
    logic        clock = 1'b0;
    logic        nrst;
    logic        clk_en;
    logic        reg_wr;
    logic        reg_rd;
    cvs_addr_t   reg_addr;
    cvs_data_t   reg_wdata;
    cvs_data_t   reg_rdata_ff;
    logic        reg_rvalid_ff;
    cvs_cells_t  cell_measure_on;
    int          mismatches = 0;
    int          total_checks = 0;
    int          seed;
    logic [31:0] r;
    logic [15:0] lo;
    logic [5:0]  hi;
    cvs_data_t   rd_d;
    logic        rd_v;

    always #12.5 clock = ~clock;

    cvs_cell_select u_cvs_cell_select (.clock(clock), .nrst(nrst),
        .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
        .cell_measure_on(cell_measure_on));

    cvs_host_model u_cvs_host_model (.clock(clock), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff));

    // ------------------------------------------------------------------
    // Expectations and comparisons
    // ------------------------------------------------------------------
    function automatic cvs_cells_t exp_vec(input logic [15:0] l,
                                           input logic [5:0] h);
        return {h[0], l};
    endfunction

    task automatic check(input string what, input logic [16:0] seen,
                         input logic [16:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A missing rvalid one cycle after the read strobe counts as a mismatch.
    task automatic rd_chk(input cvs_addr_t a, input cvs_data_t exp);
        cvs_data_t d;
        logic      v;
        u_cvs_host_model.read(a, d, v);
        check("rvalid", {16'h0000, v}, 17'h00001);
        check("rdata", {1'b0, d}, {1'b0, exp});
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        seed = 32'h1d5ec2cf;
        nrst = 1'b0;
        clk_en = 1'b1;
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        check("vector", cell_measure_on, 17'h1ffff);
        rd_chk(8'h05, 16'hffff);
        rd_chk(8'h06, 16'h0001);
        $display("test reset done");
        for (int i = 0; i < 24; i++)
        begin
            r = $random(seed);
            if (i == 0)
                r = 32'hffc0_0000;
            if (i == 1)
                r = 32'h003e_ffff;
            u_cvs_host_model.write(8'h05, r[15:0]);
            u_cvs_host_model.write(8'h06, r[31:16]);
            lo = r[15:0];
            hi = r[21:16];
            check("vector", cell_measure_on, exp_vec(lo, hi));
            rd_chk(8'h05, lo);
            rd_chk(8'h06, {10'h000, hi});
        end
        $display("test random done");
        for (int j = 0; j < 4; j++)
        begin
            r = $random(seed);
            u_cvs_host_model.write_read(8'h06, r[15:0], 8'h06, rd_d, rd_v);
            check("rsv rdata", {1'b0, rd_d}, {11'h000, r[5:0]});
            check("rsv rvalid", {16'h0000, rd_v}, 17'h00001);
            @(negedge clock);
            check("rdata hold", {1'b0, reg_rdata_ff},
                  {11'h000, r[5:0]});
            check("rvalid pulse", {16'h0000, reg_rvalid_ff},
                  17'h00000);
        end
        $display("test readback done");
        u_cvs_host_model.write(8'h05, 16'hffff);
        u_cvs_host_model.write(8'h06, 16'h0001);
        for (int n = 1; n <= 17; n++)
        begin
            u_cvs_host_model.set_cell(n, 1'b0);
            r = {15'h0000, 17'h1ffff & ~(17'h00001 << (n - 1))};
            check("walk", cell_measure_on, r[16:0]);
            u_cvs_host_model.set_cell(n, 1'b1);
        end
        $display("test walk done");
        for (int k = 0; k < 4; k++)
        begin
            u_cvs_host_model.write(8'h07 + 8'(k * 61), 16'h0000);
            rd_chk(8'h07 + 8'(k * 61), 16'h0000);
        end
        check("unmapped", cell_measure_on, 17'h1ffff);
        $display("test unmapped done");
        @(negedge clock);
        clk_en = 1'b0;
        u_cvs_host_model.write(8'h05, 16'h0000);
        check("freeze", cell_measure_on, 17'h1ffff);
        clk_en = 1'b1;
        rd_chk(8'h05, 16'hffff);
        $display("test freeze done");
        u_cvs_host_model.write(8'h05, 16'h1234);
        u_cvs_host_model.write(8'h06, 16'h003e);
        check("vector", cell_measure_on, 17'h01234);
        @(negedge clock);
        nrst = 1'b0;
        #1;
        check("async reset", cell_measure_on, 17'h1ffff);
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        rd_chk(8'h06, 16'h0001);
        rd_chk(8'h05, 16'hffff);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
